/* ee2w_regs.svh */
// Constants for the two-wire serial EEPROM slave
`ifndef EE2W_REGS_SVH
`define EE2W_REGS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define EE2W_CLK_HZ 25000000
`define EE2W_TWR_MS 5
`define EE2W_WR_CYCLES (`EE2W_TWR_MS * (`EE2W_CLK_HZ / 1000))

// ----------------------------------------
// Array and page geometry
// ----------------------------------------
`define EE2W_ARRAY_AW 13
`define EE2W_PAGE_AW 5
`define EE2W_HI_AW (`EE2W_ARRAY_AW - 8)
`define EE2W_PAGE_BYTES 32

// ----------------------------------------
// Slave address type code and bit counter values
// ----------------------------------------
// Type code value is arbitrary
`define EE2W_TYPE_CODE 4'h5
`define EE2W_LAST_BIT 4'h7
`define EE2W_ACK_BIT 4'h8
`define EE2W_PRE_BIT 4'hF

`endif

/* ee2w_pkg.sv */
// Types for the two-wire serial EEPROM slave
package ee2w_pkg;
  `include "ee2w_regs.svh"

  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_DEV  = 9'h002,
    ST_WAH  = 9'h004,
    ST_WAL  = 9'h008,
    ST_WDAT = 9'h010,
    ST_RDAT = 9'h020,
    ST_RACK = 9'h040,
    ST_WAIT = 9'h080,
    ST_BUSY = 9'h100
  } ee2w_state_t;

  typedef struct packed {
    ee2w_state_t st;
    ee2w_state_t nxtSt;
    logic sclQ;
    logic sdaQ;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic rw;
    logic ackRx;
    logic [`EE2W_ARRAY_AW-1:0] ptr;
    logic [`EE2W_HI_AW-1:0] hiAddr;
    logic [`EE2W_PAGE_BYTES-1:0] valid;
    logic pending;
    logic [31:0] busyCnt;
    logic sdaOe;
    logic sdaOut;
    logic busy;
  } ee2w_core_t;
endpackage

/* ee2w_sync.sv */
// Two-stage synchroniser for asynchronous inputs
`timescale 1ns/1ps
module ee2w_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [1:0][W-1:0] stage_r;
  logic [1:0][W-1:0] stage_nxt;

  // ----------------------------------------
  // Stage chain
  // ----------------------------------------
  always_comb begin
    stage_nxt[0] = din;
    stage_nxt[1] = stage_r[0];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage_r <= '0;
    end else begin
      stage_r <= stage_nxt;
    end
  end

  assign dout = stage_r[1];
endmodule

/* ee2w_mem.sv */
// Byte memory with registered read data
`timescale 1ns/1ps
module ee2w_mem #(
  parameter int AW = 5,
  parameter int DW = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wrEn,
  input wire logic [AW-1:0] wrAddr,
  input wire logic [DW-1:0] wrData,
  input wire logic [AW-1:0] rdAddr,
  output logic [DW-1:0] rdData
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  // ----------------------------------------
  // Write port
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  // ----------------------------------------
  // Registered read port
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData <= '0;
    end else begin
      rdData <= mem[rdAddr];
    end
  end
endmodule

/* ee2w_slave.sv */
// Two-wire serial EEPROM slave with page write and protection
`timescale 1ns/1ps
`include "ee2w_regs.svh"

module ee2w_slave #(
  parameter int unsigned WR_CYCLES = `EE2W_WR_CYCLES,
  parameter logic [3:0] TYPE_CODE = `EE2W_TYPE_CODE
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic sclPin,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic devSelBit0,
  input wire logic devSelBit1,
  input wire logic devSelBit2,
  input wire logic writeProtect,
  output logic writeBusy
);
  import ee2w_pkg::*;

  ee2w_core_t r;
  ee2w_core_t n;
  logic [5:0] pinsS;
  logic sclS;
  logic sdaS;
  logic [2:0] selS;
  logic wpS;
  logic sclRise;
  logic sclFall;
  logic startDet;
  logic stopDet;
  logic addrMatch;
  logic bufWe;
  logic [7:0] bufRd;
  logic arrWe;
  logic [`EE2W_ARRAY_AW-1:0] arrWa;
  logic [7:0] arrRd;
  logic [31:0] cpIdx;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  // straps read through synchroniser
  ee2w_sync #(.W(6)) u_sync (
    .clk(ref_clk),
    .rst_n(reset_n),
    .din({writeProtect, devSelBit2, devSelBit1, devSelBit0, sdaIn, sclPin}),
    .dout(pinsS)
  );

  assign sclS = pinsS[0];
  assign sdaS = pinsS[1];
  assign selS = pinsS[4:2];
  assign wpS = pinsS[5];

  // ----------------------------------------
  // Bus condition detection
  // ----------------------------------------
  assign sclRise = sclS & ~r.sclQ;
  assign sclFall = ~sclS & r.sclQ;
  assign startDet = sclS & r.sclQ & r.sdaQ & ~sdaS;
  assign stopDet = sclS & r.sclQ & ~r.sdaQ & sdaS;
  assign addrMatch = (r.shift[7:4] == TYPE_CODE) && (r.shift[3:1] == selS);
  assign cpIdx = r.busyCnt - 32'h1;

  // ----------------------------------------
  // Page buffer and array
  // ----------------------------------------
  ee2w_mem #(.AW(`EE2W_PAGE_AW), .DW(8)) u_page (
    .clk(ref_clk),
    .rst_n(reset_n),
    .wrEn(bufWe),
    .wrAddr(r.ptr[`EE2W_PAGE_AW-1:0]),
    .wrData(r.shift),
    .rdAddr(r.busyCnt[`EE2W_PAGE_AW-1:0]),
    .rdData(bufRd)
  );

  ee2w_mem #(.AW(`EE2W_ARRAY_AW), .DW(8)) u_array (
    .clk(ref_clk),
    .rst_n(reset_n),
    .wrEn(arrWe),
    .wrAddr(arrWa),
    .wrData(bufRd),
    .rdAddr(r.ptr),
    .rdData(arrRd)
  );

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    n = r;
    bufWe = 1'b0;
    arrWe = 1'b0;
    arrWa = {r.ptr[`EE2W_ARRAY_AW-1:`EE2W_PAGE_AW], cpIdx[`EE2W_PAGE_AW-1:0]};
    n.sclQ = sclS;
    n.sdaQ = sdaS;
    n.sdaOut = 1'b0;
    if (r.st == ST_BUSY) begin
      n.busyCnt = r.busyCnt + 32'h1;
      if ((r.busyCnt >= 32'h1) && (r.busyCnt <= 32'(`EE2W_PAGE_BYTES))) begin
        arrWe = r.valid[cpIdx[`EE2W_PAGE_AW-1:0]];
      end
      if (r.busyCnt == WR_CYCLES - 1) begin
        n.st = ST_IDLE;
        n.busy = 1'b0;
        n.valid = '0;
      end
    end else if (startDet) begin
      n.st = ST_DEV;
      // clock fall after start is no bit
      n.bitCnt = `EE2W_PRE_BIT;
      n.sdaOe = 1'b0;
      n.pending = 1'b0;
      n.valid = '0;
    end else if (stopDet) begin
      n.sdaOe = 1'b0;
      n.bitCnt = 4'h0;
      if (r.pending && !wpS) begin
        n.st = ST_BUSY;
        n.busyCnt = 32'h0;
        n.busy = 1'b1;
        n.pending = 1'b0;
      end else begin
        n.st = ST_IDLE;
        n.pending = 1'b0;
      end
    end else begin
      case (r.st)
        ST_DEV, ST_WAH, ST_WAL, ST_WDAT: begin
          if (sclRise && (r.bitCnt != `EE2W_ACK_BIT)) begin
            n.shift = {r.shift[6:0], sdaS};
          end
          if (sclFall) begin
            if (r.bitCnt == `EE2W_ACK_BIT) begin
              n.bitCnt = 4'h0;
              n.sdaOe = 1'b0;
              n.st = r.nxtSt;
              if (r.nxtSt == ST_RDAT) begin
                n.shift = arrRd;
                n.ptr = r.ptr + 13'h1;
                n.sdaOe = ~arrRd[7];
              end
            end else if (r.bitCnt == `EE2W_LAST_BIT) begin
              n.bitCnt = `EE2W_ACK_BIT;
              n.sdaOe = 1'b1;
              case (r.st)
                ST_DEV: begin
                  if (addrMatch) begin
                    n.rw = r.shift[0];
                    n.nxtSt = r.shift[0] ? ST_RDAT : ST_WAH;
                  end else begin
                    n.st = ST_WAIT;
                    n.sdaOe = 1'b0;
                    n.bitCnt = 4'h0;
                  end
                end
                ST_WAH: begin
                  n.hiAddr = r.shift[`EE2W_HI_AW-1:0];
                  n.nxtSt = ST_WAL;
                end
                ST_WAL: begin
                  n.ptr = {r.hiAddr, r.shift};
                  n.valid = '0;
                  n.nxtSt = ST_WDAT;
                end
                default: begin
                  if (wpS) begin
                    n.st = ST_WAIT;
                    n.sdaOe = 1'b0;
                    n.bitCnt = 4'h0;
                  end else begin
                    bufWe = 1'b1;
                    n.valid[r.ptr[`EE2W_PAGE_AW-1:0]] = 1'b1;
                    n.ptr[`EE2W_PAGE_AW-1:0] = r.ptr[`EE2W_PAGE_AW-1:0] + 5'h1;
                    n.pending = 1'b1;
                    n.nxtSt = ST_WDAT;
                  end
                end
              endcase
            end else begin
              n.bitCnt = r.bitCnt + 4'h1;
            end
          end
        end
        ST_RDAT: begin
          if (sclFall) begin
            if (r.bitCnt == `EE2W_LAST_BIT) begin
              n.sdaOe = 1'b0;
              n.bitCnt = `EE2W_ACK_BIT;
              n.st = ST_RACK;
            end else begin
              n.bitCnt = r.bitCnt + 4'h1;
              n.shift = {r.shift[6:0], 1'b0};
              n.sdaOe = ~r.shift[6];
            end
          end
        end
        ST_RACK: begin
          if (sclRise) begin
            n.ackRx = ~sdaS;
          end
          if (sclFall) begin
            n.bitCnt = 4'h0;
            if (r.ackRx) begin
              n.st = ST_RDAT;
              n.shift = arrRd;
              n.ptr = r.ptr + 13'h1;
              n.sdaOe = ~arrRd[7];
            end else begin
              n.st = ST_WAIT;
              n.sdaOe = 1'b0;
            end
          end
        end
        default: begin
          n.sdaOe = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '{
        st: ST_IDLE,
        nxtSt: ST_IDLE,
        sclQ: 1'b0,
        sdaQ: 1'b0,
        bitCnt: 4'h0,
        shift: 8'h00,
        rw: 1'b0,
        ackRx: 1'b0,
        ptr: '0,
        hiAddr: '0,
        valid: '0,
        pending: 1'b0,
        busyCnt: 32'h0,
        sdaOe: 1'b0,
        sdaOut: 1'b0,
        busy: 1'b0
      };
    end else begin
      r <= n;
    end
  end

  assign sdaOut = r.sdaOut;
  assign sdaOe = r.sdaOe;
  assign writeBusy = r.busy;
endmodule

/* ee2w_master.sv */
// Bus master model for the EEPROM slave
`timescale 1ns/1ps
module ee2w_master (
  input wire logic clk,
  input wire logic sdaLine,
  output logic scl,
  output logic pullLow
);
  // ----------------------------------------
  // Idle bus and bit timing
  // ----------------------------------------
  // bus idles high
  initial begin
    scl = 1'b1;
    pullLow = 1'b0;
  end
  task automatic q(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic bitx(input logic b, output logic r);
    pullLow = !b;
    q(3);
    scl = 1'b1;
    q(2);
    r = sdaLine;
    q(2);
    scl = 1'b0;
    q(1);
  endtask
  task automatic start();
    pullLow = 1'b0;
    q(3);
    scl = 1'b1;
    q(4);
    pullLow = 1'b1;
    q(4);
    scl = 1'b0;
    q(1);
  endtask
  task automatic stop();
    pullLow = 1'b1;
    q(3);
    scl = 1'b1;
    q(4);
    pullLow = 1'b0;
    q(4);
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], r);
    end
    bitx(1'b1, r);
    ack = !r;
  endtask
  task automatic rbyte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, d[i]);
    end
    bitx(!more, r);
  endtask
endmodule

/* ee2w_slave_monitor.sv */
// Protocol checker for the EEPROM slave
`timescale 1ns/1ps
module ee2w_slave_monitor #(
  parameter int unsigned WR_CYCLES = 64,
  parameter logic [3:0] TYPE_CODE = 4'h5
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic sclPin,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic devSelBit0,
  input wire logic devSelBit1,
  input wire logic devSelBit2,
  input wire logic writeProtect,
  input wire logic writeBusy
);
  logic [31:0] busyLen_r;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) busyLen_r <= 32'h0;
    else busyLen_r <= writeBusy ? busyLen_r + 32'h1 : 32'h0;
  end
  sequence sHeld;
    sdaOe [*3];
  endsequence
  sequence sQuiet;
    (!sdaOe && writeBusy) [*8];
  endsequence
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  chk_out_low: assert property (sdaOe |-> !sdaOut)
    else $error("data driven high");
  chk_edge_scl_low: assert property ($changed(sdaOe) |-> !sclPin)
    else $error("data moved while clock high");
  chk_hold_high: assert property (($rose(sclPin) && sdaOe) |=> sHeld)
    else $error("data dropped in high phase");
  chk_busy_len: assert property ($fell(writeBusy) |-> busyLen_r == WR_CYCLES)
    else $error("busy length wrong");
  chk_busy_stop: assert property ($rose(writeBusy) |-> sclPin && sdaIn)
    else $error("busy without stop");
  chk_busy_wp: assert property ($rose(writeBusy) |-> !writeProtect)
    else $error("write while protected");
  chk_busy_quiet: assert property (writeBusy |-> !sdaOe)
    else $error("drive while busy");
  chk_busy_noack: assert property ($rose(writeBusy) |-> sQuiet)
    else $error("ack while busy");
endmodule
bind ee2w_slave ee2w_slave_monitor #(.WR_CYCLES(WR_CYCLES), .TYPE_CODE(TYPE_CODE)) u_mon (.ref_clk(ref_clk),
  .reset_n(reset_n), .sclPin(sclPin), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .devSelBit0(devSelBit0),
  .devSelBit1(devSelBit1), .devSelBit2(devSelBit2), .writeProtect(writeProtect), .writeBusy(writeBusy));

/* ee2w_slave_bench.sv */
// Testbench for the EEPROM slave
`timescale 1ns/1ps
module ee2w_slave_bench;
  localparam int unsigned WRC = 200;
  // Type code value is arbitrary
  localparam logic [3:0] TC = 4'h5;
  logic clk = 1'b0;
  logic resetN;
  logic [2:0] sel;
  logic wp, scl, mLow, sdaOut, sdaOe, busy, ack;
  logic [7:0] d;
  logic [7:0] img [32];
  int errTotal, numChecks, n;
  wire sdaLine = !(mLow || (sdaOe && !sdaOut));
  logic [11:0] rows [5] = '{{3'h0, TC, 3'h0, 2'b01}, {3'h5, TC, 3'h5, 2'b01}, {3'h5, TC, 3'h4, 2'b00},
    {3'h7, ~TC, 3'h7, 2'b00}, {3'h6, TC, 3'h6, 2'b01}};
  always #20 clk = ~clk;
  ee2w_slave #(.WR_CYCLES(WRC), .TYPE_CODE(TC)) u_dut (.ref_clk(clk), .reset_n(resetN), .sclPin(scl),
    .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .devSelBit0(sel[0]), .devSelBit1(sel[1]),
    .devSelBit2(sel[2]), .writeProtect(wp), .writeBusy(busy));
  ee2w_master u_mst (.clk(clk), .sdaLine(sdaLine), .scl(scl), .pullLow(mLow));
  // ----------------------------------------
  // Checks and helpers
  // ----------------------------------------
  task automatic chkA(input logic got, input logic exp);
    numChecks++;
    if (got !== exp) begin
      errTotal++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chkB(input logic [7:0] got, input logic [7:0] exp);
    numChecks++;
    if (got !== exp) begin
      errTotal++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic giveVerdict();
    $display("checks %0d errors %0d", numChecks, errTotal);
    if (errTotal == 0 && numChecks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic addrW(input logic [7:0] hi, input logic [7:0] lo);
    u_mst.start();
    u_mst.wbyte({TC, sel, 1'b0}, ack);
    chkA(ack, 1'b1);
    u_mst.wbyte(hi, ack);
    chkA(ack, 1'b1);
    u_mst.wbyte(lo, ack);
    chkA(ack, 1'b1);
  endtask
  task automatic rdChk(input int off, input int cnt);
    u_mst.start();
    u_mst.wbyte({TC, sel, 1'b1}, ack);
    chkA(ack, 1'b1);
    for (int i = 0; i < cnt; i++) begin
      u_mst.rbyte(i < cnt - 1, d);
      chkB(d, img[off + i]);
    end
    u_mst.stop();
  endtask
  task automatic busyPoll();
    chkA(busy, 1'b1);
    u_mst.start();
    u_mst.wbyte({TC, sel, 1'b0}, ack);
    chkA(ack, 1'b0);
    u_mst.stop();
    for (n = 0; n < 300 && busy !== 1'b0; n++) begin
      @(posedge clk);
      #1;
    end
    chkA(busy, 1'b0);
    u_mst.start();
    u_mst.wbyte({TC, sel, 1'b0}, ack);
    chkA(ack, 1'b1);
    u_mst.stop();
  endtask
  initial begin
    repeat (40000) @(posedge clk);
    errTotal++;
    giveVerdict();
  end
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    resetN = 1'b0;
    sel = 3'h0;
    wp = 1'b0;
    errTotal = 0;
    numChecks = 0;
    repeat (20) @(posedge clk);
    #1;
    resetN = 1'b1;
    chkA(sdaOe, 1'b0);
    chkA(sdaOut, 1'b0);
    chkA(busy, 1'b0);
    foreach (rows[i]) begin
      sel = rows[i][11:9];
      u_mst.q(6);
      u_mst.start();
      u_mst.wbyte(rows[i][8:1], ack);
      chkA(ack, rows[i][0]);
      u_mst.stop();
      $display("row %0d done", i);
    end
    addrW(8'hFF, 8'h3E);
    for (int i = 0; i < 34; i++) begin
      u_mst.wbyte(8'(i) ^ 8'h5A, ack);
      chkA(ack, 1'b1);
      img[(30 + i) % 32] = 8'(i) ^ 8'h5A;
    end
    u_mst.stop();
    busyPoll();
    addrW(8'h1F, 8'h20);
    rdChk(0, 31);
    rdChk(31, 1);
    $display("page test done");
    wp = 1'b1;
    u_mst.q(6);
    addrW(8'h1F, 8'h24);
    u_mst.wbyte(8'hEE, ack);
    chkA(ack, 1'b0);
    u_mst.stop();
    u_mst.q(4);
    chkA(busy, 1'b0);
    wp = 1'b0;
    u_mst.q(6);
    addrW(8'h1F, 8'h25);
    for (int i = 0; i < 2; i++) begin
      u_mst.wbyte(8'h11 << i, ack);
      chkA(ack, 1'b1);
      img[5 + i] = 8'h11 << i;
    end
    u_mst.stop();
    busyPoll();
    addrW(8'h1F, 8'h24);
    rdChk(4, 4);
    $display("protect test done");
    giveVerdict();
  end
endmodule
